// *** sysref_host_pkg.sv ***
// constants shared by the sysref host controller: apb map, device register
// map, device field layouts, serial frame layout and timing counts.
// assumes the device takes 24-bit serial write frames, msb first.
package sysref_host_pkg;

  // own registers, byte addresses on apb
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] CONFIG_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // ctrl fields
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_TRIGGER_BIT = 1;
  localparam int CTRL_REQUEST_BIT = 2;
  localparam int CTRL_DDLY_PD_BIT = 3;
  // config fields
  localparam int CFG_COUNT_LSB = 0;
  localparam int CFG_MODE_LSB  = 2;
  localparam logic [3:0] CONFIG_RESET = 4'h1;

  typedef enum logic [1:0] {
    OP_PULSER_PIN = 2'h0,
    OP_PULSER_SPI = 2'h1,
    OP_CONTINUOUS = 2'h2,
    OP_REQUEST    = 2'h3
  } op_mode_e;

  // device register map
  localparam logic [14:0] DEV_PULSE_COUNT = 15'h013e;
  localparam logic [14:0] DEV_SOURCE_SEL  = 15'h013f;
  localparam logic [14:0] DEV_POWER       = 15'h0140;
  localparam logic [14:0] DEV_SYNC_CLEAR  = 15'h0143;
  localparam logic [14:0] DEV_SYNC_DIS    = 15'h0144;

  // device field positions
  localparam int SYSREF_POWER_DOWN_BIT   = 0;
  localparam int GLOBAL_DDLY_BIT = 1;
  localparam int PULSER_PD_BIT   = 2;
  localparam int REQ_EN_BIT      = 6;
  localparam int SYNC_POLARITY_INVERT_BIT    = 5;
  localparam int SYNC_EN_BIT     = 4;
  localparam int LOCAL_CLEAR_BIT = 7;
  localparam int SYNC_MODE_LSB   = 0;

  // source select and sync mode codes
  localparam logic [1:0] SRC_NORMAL     = 2'h0;
  localparam logic [1:0] SRC_PULSER     = 2'h2;
  localparam logic [1:0] SRC_CONTINUOUS = 2'h3;
  localparam logic [1:0] SMODE_OFF      = 2'h0;
  localparam logic [1:0] SMODE_MANUAL   = 2'h1;
  localparam logic [1:0] SMODE_PIN      = 2'h2;
  localparam logic [1:0] SMODE_SPI      = 2'h3;
  localparam logic [7:0] ALL_SYNC_DIS   = 8'hff;
  localparam logic [7:0] NO_SYNC_DIS    = 8'h00;

  // serial frame
  localparam int FRAME_BITS = 24;

  // sequence step indices
  localparam logic [3:0] STEP_LAST_PREP = 4'h7;
  localparam logic [3:0] STEP_LAST      = 4'ha;
  localparam logic [3:0] STEP_TRIGGER   = 4'hb;

  // timing: clock 20 MHz, clear held at least 15 vco cycles; the vco is far
  // faster than clk_in, so 15 clk_in cycles always cover it
  localparam int CLK_HZ            = 20_000_000;
  localparam int CLEAR_HOLD_CYCLES = 15;
  localparam int SYNC_PULSE_NS     = 1000;
  localparam int SYNC_PULSE_CYCLES =
    (SYNC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

// *** sysref_host.sv ***
// host controller that programs the sysref generator of a clock device over
// its serial control port and drives its sync / request pin.
// assumes apb on clk_in and a device that samples sdio on rising sclk.
`timescale 1ns/10ps

module sysref_host #(
  parameter int CLEAR_HOLD = sysref_host_pkg::CLEAR_HOLD_CYCLES,
  parameter int SYNC_PULSE = sysref_host_pkg::SYNC_PULSE_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             spi_sclk_out,
  output logic             spi_sdio_out,
  output logic             spi_cs_n_out,
  output logic             sync_pin_out
);

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_LOAD  = 3'b001,
    SEQ_SHIFT = 3'b011,
    SEQ_GAP   = 3'b010,
    SEQ_HOLD  = 3'b110,
    SEQ_PULSE = 3'b100
  } seq_state_e;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(CLEAR_HOLD - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(SYNC_PULSE - 1);
  localparam logic [4:0] FRAME_LAST = 5'(sysref_host_pkg::FRAME_BITS - 1);

  // apb decode
  wire logic setup_phase = psel_in & ~penable_in;
  wire logic access      = psel_in & penable_in;
  wire logic hit_ctrl    = paddr_in == sysref_host_pkg::CTRL_OFFSET;
  wire logic hit_config  = paddr_in == sysref_host_pkg::CONFIG_OFFSET;
  wire logic hit_status  = paddr_in == sysref_host_pkg::STATUS_OFFSET;
  wire logic hit_any     = hit_ctrl | hit_config | hit_status;
  wire logic wr_ctrl     = access & pwrite_in & hit_ctrl;
  wire logic wr_config   = access & pwrite_in & hit_config;

  logic             request_reg;
  logic             ddly_pd_reg;
  logic [3:0]       config_reg;
  logic             done_reg;
  logic             refused_reg;
  logic [31:0]      rdata_reg;
  logic             err_reg;
  seq_state_e       state_reg;
  seq_state_e       state_next;
  logic [3:0]       step_reg;
  logic [3:0]       step_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [23:0]      shift_reg;
  logic [4:0]       bit_reg;
  logic             sclk_reg;
  logic             cs_n_reg;
  logic             pin_reg;

  wire logic [1:0] count_code =
    config_reg[sysref_host_pkg::CFG_COUNT_LSB +: 2];
  wire sysref_host_pkg::op_mode_e op_mode = sysref_host_pkg::op_mode_e'(
    config_reg[sysref_host_pkg::CFG_MODE_LSB +: 2]);
  wire logic busy   = state_reg != SEQ_IDLE;
  wire logic start  = wr_ctrl & pwdata_in[sysref_host_pkg::CTRL_START_BIT];
  wire logic trig   = wr_ctrl & pwdata_in[sysref_host_pkg::CTRL_TRIGGER_BIT];
  wire logic go     = (start | trig) & ~busy;

  // mode dependent values for the final device setup
  wire logic pulser_off = op_mode == sysref_host_pkg::OP_CONTINUOUS;
  logic [1:0] final_smode;
  logic [1:0] final_src;
  always_comb begin
    case (op_mode)
      sysref_host_pkg::OP_PULSER_PIN: begin
        final_smode = sysref_host_pkg::SMODE_PIN;
        final_src   = sysref_host_pkg::SRC_PULSER;
      end
      sysref_host_pkg::OP_PULSER_SPI: begin
        final_smode = sysref_host_pkg::SMODE_SPI;
        final_src   = sysref_host_pkg::SRC_PULSER;
      end
      sysref_host_pkg::OP_CONTINUOUS: begin
        final_smode = sysref_host_pkg::SMODE_OFF;
        final_src   = sysref_host_pkg::SRC_CONTINUOUS;
      end
      default: begin
        final_smode = sysref_host_pkg::SMODE_OFF;
        final_src   = sysref_host_pkg::SRC_PULSER;
      end
    endcase
  end

  // step table: device address and data for each write of the sequence
  logic [14:0] step_addr;
  logic [7:0]  step_data;
  always_comb begin
    step_addr = sysref_host_pkg::DEV_SYNC_CLEAR;
    step_data = 8'h00;
    step_data[sysref_host_pkg::SYNC_EN_BIT] = 1'b1;
    step_data[sysref_host_pkg::LOCAL_CLEAR_BIT] = 1'b1;
    step_data[sysref_host_pkg::SYNC_MODE_LSB +: 2] =
      sysref_host_pkg::SMODE_MANUAL;
    case (step_reg)
      4'h0: begin
        // sysref and global delay powered, pulser per mode
        step_addr = sysref_host_pkg::DEV_POWER;
        step_data = 8'h00;
        step_data[sysref_host_pkg::PULSER_PD_BIT] = pulser_off;
      end
      4'h1: begin
        step_addr = sysref_host_pkg::DEV_SOURCE_SEL;
        step_data = {6'h00, sysref_host_pkg::SRC_NORMAL};
      end
      4'h2, sysref_host_pkg::STEP_TRIGGER: begin
        // rewriting the count in spi mode fires a burst
        step_addr = sysref_host_pkg::DEV_PULSE_COUNT;
        step_data = {6'h00, count_code};
      end
      4'h3: begin
      end
      4'h4: begin
        step_addr = sysref_host_pkg::DEV_SYNC_DIS;
        step_data = sysref_host_pkg::NO_SYNC_DIS;
      end
      4'h5: begin
        step_data[sysref_host_pkg::SYNC_POLARITY_INVERT_BIT] = 1'b1;
      end
      4'h6: begin
      end
      sysref_host_pkg::STEP_LAST_PREP: begin
        step_addr = sysref_host_pkg::DEV_SYNC_DIS;
        step_data = sysref_host_pkg::ALL_SYNC_DIS;
      end
      4'h8: begin
        // clear released only after dividers are aligned
        step_data[sysref_host_pkg::LOCAL_CLEAR_BIT] = 1'b0;
        step_data[sysref_host_pkg::SYNC_MODE_LSB +: 2] = final_smode;
      end
      4'h9: begin
        step_addr = sysref_host_pkg::DEV_SOURCE_SEL;
        step_data = {6'h00, final_src};
        step_data[sysref_host_pkg::REQ_EN_BIT] =
          op_mode == sysref_host_pkg::OP_REQUEST;
      end
      default: begin
        step_addr = sysref_host_pkg::DEV_POWER;
        step_data = 8'h00;
        step_data[sysref_host_pkg::PULSER_PD_BIT] = pulser_off;
        step_data[sysref_host_pkg::GLOBAL_DDLY_BIT] = ddly_pd_reg;
      end
    endcase
  end

  wire logic frame_end = sclk_reg & (bit_reg == FRAME_LAST);
  wire logic seq_last  = step_reg == sysref_host_pkg::STEP_LAST;
  wire logic pin_trig  = op_mode == sysref_host_pkg::OP_PULSER_PIN;

  // sequencer
  always_comb begin
    state_next = state_reg;
    step_next  = step_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      SEQ_IDLE: begin
        cnt_next = '0;
        if (go & start) begin
          step_next  = 4'h0;
          state_next = SEQ_LOAD;
        end else if (go & pin_trig) begin
          state_next = SEQ_PULSE;
        end else if (go) begin
          step_next  = sysref_host_pkg::STEP_TRIGGER;
          state_next = SEQ_LOAD;
        end
      end
      SEQ_LOAD: state_next = SEQ_SHIFT;
      SEQ_SHIFT: begin
        if (frame_end) begin
          state_next = SEQ_GAP;
        end
      end
      SEQ_GAP: begin
        if (step_reg == sysref_host_pkg::STEP_LAST_PREP) begin
          state_next = SEQ_HOLD;
        end else if (seq_last | step_reg == sysref_host_pkg::STEP_TRIGGER)
        begin
          state_next = SEQ_IDLE;
        end else begin
          step_next  = step_reg + 4'h1;
          state_next = SEQ_LOAD;
        end
      end
      SEQ_HOLD: begin
        // clear has been set since step 3; make sure it lasted long enough
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg >= HOLD_LAST) begin
          cnt_next   = '0;
          step_next  = step_reg + 4'h1;
          state_next = SEQ_LOAD;
        end
      end
      SEQ_PULSE: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg >= PULSE_LAST) begin
          state_next = SEQ_IDLE;
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= SEQ_IDLE;
      step_reg  <= 4'h0;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      cnt_reg   <= cnt_next;
    end
  end

  // serial frame: write flag 0, address, data; sclk is clk_in / 2
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shift_reg <= 24'h000000;
      bit_reg   <= 5'h00;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
    end else if (state_reg == SEQ_LOAD) begin
      shift_reg <= {1'b0, step_addr, step_data};
      bit_reg   <= 5'h00;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b0;
    end else if (state_reg == SEQ_SHIFT) begin
      sclk_reg <= ~sclk_reg;
      if (sclk_reg) begin
        shift_reg <= {shift_reg[22:0], 1'b0};
        bit_reg   <= bit_reg + 5'h01;
      end
      cs_n_reg <= frame_end;
    end else begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end
  end

  // sync pin: a timed pulse, or the request level in request mode
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_reg <= 1'b0;
    end else if (op_mode == sysref_host_pkg::OP_REQUEST && !busy) begin
      pin_reg <= request_reg;
    end else begin
      pin_reg <= state_next == SEQ_PULSE;
    end
  end

  // own registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      request_reg <= 1'b0;
      ddly_pd_reg <= 1'b0;
      config_reg  <= sysref_host_pkg::CONFIG_RESET;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        request_reg <= pwdata_in[sysref_host_pkg::CTRL_REQUEST_BIT];
        ddly_pd_reg <= pwdata_in[sysref_host_pkg::CTRL_DDLY_PD_BIT];
      end
      // config frozen while a sequence uses it
      if (wr_config && !busy) begin
        config_reg <= pwdata_in[3:0];
      end
      if (state_reg == SEQ_GAP && seq_last) begin
        done_reg <= 1'b1;
      end else if (start & ~busy) begin
        done_reg <= 1'b0;
      end
      if ((start | trig) & busy) begin
        refused_reg <= 1'b1;
      end else if (wr_ctrl) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // read data captured in the setup phase, answered in the access phase
  wire logic [31:0] status_word = {20'h00000, step_reg, 1'b0, state_reg,
                                   1'b0, refused_reg, done_reg, busy};
  wire logic [31:0] ctrl_word = {28'h0000000, ddly_pd_reg, request_reg, 2'b00};
  wire logic [31:0] rd_mux =
    hit_ctrl   ? ctrl_word :
    hit_config ? {28'h0000000, config_reg} :
    hit_status ? status_word : 32'h00000000;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 32'h00000000;
      err_reg   <= 1'b0;
    end else if (setup_phase) begin
      rdata_reg <= pwrite_in ? 32'h00000000 : rd_mux;
      err_reg   <= ~hit_any;
    end
  end

  assign prdata_out   = rdata_reg;
  assign pready_out   = 1'b1;
  assign pslverr_out  = access & err_reg;
  assign spi_sclk_out = sclk_reg;
  assign spi_sdio_out = shift_reg[23];
  assign spi_cs_n_out = cs_n_reg;
  assign sync_pin_out = pin_reg;

endmodule

// *** sysref_dev_model.sv ***
// device model: decodes 24-bit serial writes and keeps sysref registers.
// assumes frames msb first, sampled on rising sclk while cs_n is low.
`timescale 1ns/10ps
module sysref_dev_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        sdio_in,
  input  wire logic        cs_n_in,
  input  wire logic        sync_in,
  output logic             wr_stb_out,
  output logic [22:0]      wr_word_out,
  output int               pulses_out,
  output logic             cont_on_out,
  output logic             req_on_out,
  output int               aligns_out
);
  logic [7:0]  regs [0:6];
  logic [23:0] sh;
  int          nb;
  logic        sclk_d;
  logic        cs_d;
  logic        sync_d;
  wire  [7:0]  sc     = regs[5];
  wire         armed  = sc[4] && !sc[7];
  wire         pulsed = regs[1][1:0] == 2'h2;
  assign cont_on_out = regs[1][1:0] == 2'h3 && !regs[2][0] && armed;
  assign req_on_out  = regs[1][6] && pulsed && sync_in && armed;
  always @(posedge clk_in) begin
    wr_stb_out <= 1'b0;
    sclk_d <= sclk_in;
    cs_d <= cs_n_in;
    sync_d <= sync_in;
    if (rst_in) begin
      regs <= '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h80, 8'h00};
      nb <= 0;
      pulses_out <= 0;
      aligns_out <= 0;
    end else begin
      if (!cs_n_in && sclk_in && !sclk_d) begin
        sh <= {sh[22:0], sdio_in};
        nb <= nb + 1;
      end
      if (cs_n_in && !cs_d) begin
        nb <= 0;
        if (nb == 24 && !sh[23]) begin
          wr_stb_out <= 1'b1;
          wr_word_out <= sh[22:0];
          if (sh[22:8] >= 15'h013e && sh[22:8] <= 15'h0144)
            regs[sh[22:8] - 15'h013e] <= sh[7:0];
          // polarity falling back ends the sync; enabled dividers restart
          if (sh[22:8] == 15'h0143 && sc[5] && !sh[5] && sh[4] &&
              regs[6] != 8'hff)
            aligns_out <= aligns_out + 1;
          if (sh[22:8] == 15'h013e && sc[1:0] == 2'h3 && pulsed && armed)
            pulses_out <= pulses_out + (1 << sh[1:0]);
        end
      end
      if (sync_in && !sync_d && sc[1:0] == 2'h2 && pulsed && armed)
        pulses_out <= pulses_out + (1 << regs[0][1:0]);
    end
  end
endmodule

// *** sysref_host_sva.sv ***
// assertions on the sysref host ports: apb answers and serial framing.
// assumes one clock domain with synchronous reset.
`timescale 1ns/10ps
module sysref_host_sva #(
  parameter int CLEAR_HOLD = 15,
  parameter int SYNC_PULSE = 20
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        spi_sclk_out,
  input wire logic        spi_sdio_out,
  input wire logic        spi_cs_n_out,
  input wire logic        sync_pin_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] low_cnt_reg;
  wire        acc = psel_in && penable_in;
  wire        mapped = paddr_in == 12'h000 || paddr_in == 12'h004 ||
                       paddr_in == 12'h008;
  // counts low cycles of the frame select; a frame is 24 bits of 2 cycles
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || spi_cs_n_out) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  ready_always_a: assert property (pready_out)
    else $error("apb ready dropped");
  unmapped_err_a: assert property (acc && !mapped |->
    pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr_out)
    else $error("mapped access refused");
  sclk_idle_a: assert property (spi_cs_n_out |-> !spi_sclk_out)
    else $error("serial clock outside frame");
  sclk_high_a: assert property (spi_sclk_out |=> !spi_sclk_out)
    else $error("serial clock high too long");
  sdio_hold_a: assert property ($rose(spi_sclk_out) |-> $stable(spi_sdio_out))
    else $error("data moved at rising serial clock");
  frame_len_a: assert property ($rose(spi_cs_n_out) |-> low_cnt_reg == 8'h30)
    else $error("frame length wrong");
  frame_gap_a: assert property ($rose(spi_cs_n_out) |=> spi_cs_n_out)
    else $error("no idle cycle between frames");
  write_bit_a: assert property ($fell(spi_cs_n_out) |->
    !spi_sdio_out && !spi_sclk_out ##1 spi_sclk_out)
    else $error("frame start wrong");
  sync_quiet_a: assert property (
    $rose(sync_pin_out) |-> spi_cs_n_out)
    else $error("sync pin raised during a frame");
endmodule
bind sysref_host sysref_host_sva #(.CLEAR_HOLD(CLEAR_HOLD),
  .SYNC_PULSE(SYNC_PULSE)) u_sysref_host_sva (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .spi_sclk_out(spi_sclk_out),
  .spi_sdio_out(spi_sdio_out), .spi_cs_n_out(spi_cs_n_out),
  .sync_pin_out(sync_pin_out));

// *** sysref_host_tb.sv ***
// testbench for sysref host: apb master, device model, frame scoreboard.
// assumes the device model reports every serial write it decodes.
`timescale 1ns/10ps
module sysref_host_tb;
  localparam int PULSE = 4;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rd, seed = 32'h18;
  logic        pready_out, pslverr_out, spi_sclk_out, spi_sdio_out;
  logic        spi_cs_n_out, sync_pin_out, wr_stb, cont_on, req_on;
  logic [22:0] wr_word;
  logic [22:0] fr_q [$];
  logic [33:0] ap_q [$];
  logic [33:0] ap;
  int          pulses, p, n, aligns, al, pin_hi = 0;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  always #25 clk_in = ~clk_in;
  sysref_host #(.CLEAR_HOLD(3), .SYNC_PULSE(PULSE)) u_sysref_host (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .spi_sclk_out(spi_sclk_out),
    .spi_sdio_out(spi_sdio_out), .spi_cs_n_out(spi_cs_n_out),
    .sync_pin_out(sync_pin_out));
  sysref_dev_model u_sysref_dev_model (.clk_in(clk_in), .rst_in(sys_rst_in),
    .sclk_in(spi_sclk_out), .sdio_in(spi_sdio_out), .cs_n_in(spi_cs_n_out),
    .sync_in(sync_pin_out), .wr_stb_out(wr_stb), .wr_word_out(wr_word),
    .pulses_out(pulses), .cont_on_out(cont_on), .req_on_out(req_on),
    .aligns_out(aligns));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic chk,
                     input logic [31:0] e, input logic err);
    ap_q.push_back({chk && !w, err, e});
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // scoreboard: pops the oldest note whenever a result shows up
  always @(posedge clk_in) begin
    cycles++;
    // counted here so the cycle the pin rises is never missed
    if (sync_pin_out === 1'b1) pin_hi++;
    if (psel_in && penable_in && pready_out) begin
      ap = ap_q.pop_front();
      check(pslverr_out, ap[32]);
      if (ap[33]) check(prdata_out, ap[31:0]);
    end
    if (wr_stb === 1'b1)
      check({9'h0, wr_word}, fr_q.size() ? {9'h0, fr_q.pop_front()} : 'x);
    if (cycles > 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic run_setup(input logic [1:0] m, input logic [1:0] c,
                           input logic d);
    logic [7:0] pp;
    pp = (m == 2'h2) ? 8'h04 : 8'h00;
    al = aligns;
    apb(1, 12'h004, {28'h0, m, c}, 0, 0, 0);
    fr_q.push_back({15'h0140, pp});
    fr_q.push_back({15'h013f, 8'h00});
    fr_q.push_back({15'h013e, 6'h0, c});
    fr_q.push_back({15'h0143, 8'h91});
    fr_q.push_back({15'h0144, 8'h00});
    fr_q.push_back({15'h0143, 8'hb1});
    fr_q.push_back({15'h0143, 8'h91});
    fr_q.push_back({15'h0144, 8'hff});
    fr_q.push_back({15'h0143, m[1] ? 8'h10 : {6'h04, 1'b1, m[0]}});
    fr_q.push_back({15'h013f, m == 2'h3 ? 8'h42 : {7'h01, m == 2'h2}});
    fr_q.push_back({15'h0140, pp | {6'h0, d, 1'b0}});
    apb(1, 12'h000, {28'h0, d, 3'h1}, 0, 0, 0);
    // busy: a second start and a config change must both be ignored
    apb(1, 12'h004, {28'h0, ~m, ~c}, 0, 0, 0);
    apb(1, 12'h000, {28'h0, d, 3'h1}, 0, 0, 0);
    apb(0, 12'h008, 0, 0, 0, 0);
    check(rd[2:0], 3'h5);
    apb(0, 12'h004, 0, 1, {28'h0, m, c}, 0);
    repeat (2000) begin
      apb(0, 12'h008, 0, 0, 0, 0);
      if (rd[0] === 1'b0) break;
    end
    check(rd[1:0], 2'h2);
    check(fr_q.size(), 0);
    check(aligns - al, 1);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    apb(0, 12'h004, 0, 1, 32'h1, 0);
    apb(0, 12'h000, 0, 1, 32'h0, 0);
    apb(1, 12'h00c, 32'hffff, 0, 0, 1);
    apb(0, 12'h00c, 0, 1, 32'h0, 1);
    for (int m = 0; m < 4; m++) begin
      seed = xs(seed);
      run_setup(m[1:0], seed[1:0], seed[2]);
      p = pulses;
      if (m != 0) fr_q.push_back({15'h013e, 6'h0, seed[1:0]});
      n = pin_hi;
      al = aligns;
      apb(1, 12'h000, {28'h0, seed[2], 3'h2}, 0, 0, 0);
      repeat (200) @(posedge clk_in);
      check(pin_hi - n, m == 0 ? PULSE : 0);
      check(aligns - al, 0);
      check(pulses - p, m > 1 ? 0 : 1 << seed[1:0]);
      check(cont_on, m == 2);
      apb(1, 12'h000, {28'h0, seed[2], 3'h4}, 0, 0, 0);
      // the pin follows the stored request one cycle late
      @(posedge clk_in);
      check(req_on, m == 3);
      apb(1, 12'h000, {28'h0, seed[2], 3'h0}, 0, 0, 0);
      @(posedge clk_in);
      check({sync_pin_out, req_on}, 0);
      $display("mode %0d test done", m);
    end
    run_setup(2'h0, 2'h1, 1'b0);
    // only the first frame completes before the reset cuts the sequence
    fr_q.push_back({15'h0140, 8'h00});
    apb(1, 12'h000, 32'h1, 0, 0, 0);
    repeat (60) @(posedge clk_in);
    check(fr_q.size(), 0);
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    fr_q.delete();
    @(posedge clk_in);
    check({spi_cs_n_out, sync_pin_out}, 2'h2);
    apb(0, 12'h004, 0, 1, 32'h1, 0);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
